/* File: src/cirq_map.vh */
`ifndef CIRQ_MAP_VH
`define CIRQ_MAP_VH

// Register byte offsets
`define CIRQ_CTRL_OFS       8'h00
`define CIRQ_MASK_SET_OFS   8'h10
`define CIRQ_MASK_CLR_OFS   8'h14
`define CIRQ_MASK_OFS       8'h18
`define CIRQ_PEND_OFS       8'h1c
`define CIRQ_PEND_CLR_OFS   8'h20
`define CIRQ_OVR_OFS        8'h24
`define CIRQ_CAP_OFS        8'h30
`define CIRQ_REV_OFS        8'h34
`define CIRQ_SUT_OFS        8'h38

// Field positions
`define CIRQ_WIN_LSB        24
`define CIRQ_CAP_WIN_LSB    16
`define CIRQ_REV_VAR_LSB    16
`define CIRQ_CTRL_OVR_BIT   7
`define CIRQ_CTRL_EN_BIT    0

// Writable bits of the interrupt registers
`define CIRQ_IRQ_VALID      32'h0f00_ffff

// Reset values
`define CIRQ_RST_ZERO       32'h0000_0000
`define CIRQ_RST_SUT        10'h000

// Arbitrary neutral identity values
`define CIRQ_REV_NUMBER     12'h001
`define CIRQ_REV_VARIANT    4'h0

`endif

/* File: src/cirq_sync.v */
`timescale 1ns/10ps
module cirq_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Asynchronous inputs and filtered result
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] s1_ff;
  reg [WIDTH-1:0] s2_ff;
  reg [WIDTH-1:0] s3_ff;
  reg [WIDTH-1:0] out_ff;

  // A change is taken only once the second and third stage agree
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1_ff <= {WIDTH{1'b0}};
      s2_ff <= {WIDTH{1'b0}};
      s3_ff <= {WIDTH{1'b0}};
      out_ff <= {WIDTH{1'b0}};
    end else begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= (s2_ff & s3_ff) | (out_ff & (s2_ff | s3_ff));
    end
  end

  assign sync_o = out_ff;

endmodule

/* File: src/cirq_regs.v */
// Function
// - One mask bit per source, fixed positions
// - Set-strobe ones set matching mask bits
// - Clear-strobe ones clear matching mask bits
// - Window-pair event sets sticky pending flag
// - Startup time elapsed sets startup flag
// - Comparator event sets normal pending flag
// - Pending read-only, cleared by writing one
// - Writing zero to clear leaves flag
// - Clearing flag also withdraws its interrupt
// - Override selects test bits as outputs
// - Capability bits 16-19 show window pairs
// - Capability bits 0-7 show comparators
// - Read-only revision: number and variant
// - Override select is control bit 7
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`include "cirq_map.vh"
module cirq_regs #(
  parameter NUM_CMP = 8,
  parameter NUM_WIN = 4,
  parameter [7:0] CMP_PRESENT = 8'hff,
  parameter [3:0] WIN_PRESENT = 4'hf,
  parameter [11:0] REV_NUMBER = `CIRQ_REV_NUMBER,
  parameter [3:0] REV_VARIANT = `CIRQ_REV_VARIANT
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output wire [31:0] rdata_o,
  // Comparator side (asynchronous)
  input wire [NUM_CMP-1:0] comparator_n_i,
  input wire [NUM_CMP-1:0] comparator_irq_i,
  input wire [NUM_WIN-1:0] window_pair_irq_i,
  input wire [NUM_CMP-1:0] cmp_enable_i,
  // Channel logic side
  output wire [NUM_CMP-1:0] cmp_out_o,
  output wire [NUM_CMP-1:0] cmp_ready_o,
  // Interrupt
  output wire irq_o
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // Packs per-source vectors into the shared interrupt layout
  function [31:0] irq_pack;
    input [7:0] cmp_bits;
    input [7:0] sut_bits;
    input [3:0] win_bits;
    integer k;
    begin
      irq_pack = `CIRQ_RST_ZERO;
      for (k = 0; k < 8; k = k + 1) begin
        irq_pack[2*k] = cmp_bits[k];
        irq_pack[2*k+1] = sut_bits[k];
      end
      irq_pack[`CIRQ_WIN_LSB +: 4] = win_bits;
    end
  endfunction

  wire wr_ctrl = wr_i & hit(addr_i, `CIRQ_CTRL_OFS);
  wire wr_mset = wr_i & hit(addr_i, `CIRQ_MASK_SET_OFS);
  wire wr_mclr = wr_i & hit(addr_i, `CIRQ_MASK_CLR_OFS);
  wire wr_pclr = wr_i & hit(addr_i, `CIRQ_PEND_CLR_OFS);
  wire wr_ovr = wr_i & hit(addr_i, `CIRQ_OVR_OFS);
  wire wr_sut = wr_i & hit(addr_i, `CIRQ_SUT_OFS);

  // ----------------------------------------------------------------
  // Synchronisers for asynchronous comparator signals
  // ----------------------------------------------------------------
  localparam SW = 3 * NUM_CMP + NUM_WIN;
  wire [SW-1:0] sync_vec;

  cirq_sync #(
    .WIDTH(SW)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i({window_pair_irq_i, cmp_enable_i, comparator_irq_i, comparator_n_i}),
    .sync_o(sync_vec)
  );

  wire [NUM_CMP-1:0] cmp_s = sync_vec[NUM_CMP-1:0];
  wire [NUM_CMP-1:0] cirq_s = sync_vec[2*NUM_CMP-1:NUM_CMP];
  wire [NUM_CMP-1:0] en_s = sync_vec[3*NUM_CMP-1:2*NUM_CMP];
  wire [NUM_WIN-1:0] win_s = sync_vec[SW-1:3*NUM_CMP];

  reg [NUM_CMP-1:0] cirq_d_ff;
  reg [NUM_WIN-1:0] win_d_ff;
  reg [NUM_CMP-1:0] en_d_ff;

  // ----------------------------------------------------------------
  // Control, override and startup time
  // ----------------------------------------------------------------
  reg [31:0] ctrl_ff;
  reg [7:0] ovr_ff;
  reg [9:0] sut_ff;

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_ff <= `CIRQ_RST_ZERO;
      ovr_ff <= 8'h00;
      sut_ff <= `CIRQ_RST_SUT;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= {24'h00_0000, wdata_i[`CIRQ_CTRL_OVR_BIT], 6'h00,
                    wdata_i[`CIRQ_CTRL_EN_BIT]};
      end
      if (wr_ovr) begin
        ovr_ff <= wdata_i[7:0];
      end
      if (wr_sut) begin
        sut_ff <= wdata_i[9:0];
      end
    end
  end

  wire override_select = ctrl_ff[`CIRQ_CTRL_OVR_BIT];
  // Override bypasses the pin path for cmp_out_o only; pending flags and cmp_ready_o still follow the pins
  assign cmp_out_o = override_select ? ovr_ff[NUM_CMP-1:0] : cmp_s;

  // ----------------------------------------------------------------
  // Startup timers, one per comparator
  // ----------------------------------------------------------------
  // Each timer keeps its own flops, so every bit has exactly one driver
  wire [NUM_CMP-1:0] sut_done;
  wire [NUM_CMP-1:0] ready_vec;
  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g = g + 1) begin : g_sut
      reg [9:0] cnt_ff;
      reg run_ff;
      reg rdy_ff;
      always @(posedge ref_clk_i) begin
        if (rst_i) begin
          cnt_ff <= 10'h000;
          run_ff <= 1'b0;
          rdy_ff <= 1'b0;
        end else if (!en_s[g]) begin
          cnt_ff <= 10'h000;
          run_ff <= 1'b0;
          rdy_ff <= 1'b0;
        end else if (en_s[g] && !en_d_ff[g]) begin
          cnt_ff <= 10'h000;
          run_ff <= 1'b1;
          rdy_ff <= 1'b0;
        end else if (run_ff) begin
          if (cnt_ff >= sut_ff) begin
            run_ff <= 1'b0;
            rdy_ff <= 1'b1;
          end else begin
            cnt_ff <= cnt_ff + 10'h001;
          end
        end
      end
      // One-cycle pulse as the count reaches the programmed time
      assign sut_done[g] = run_ff & (cnt_ff >= sut_ff);
      assign ready_vec[g] = rdy_ff;
    end
  endgenerate

  assign cmp_ready_o = ready_vec;

  // ----------------------------------------------------------------
  // Mask and pending flags
  // ----------------------------------------------------------------
  reg [31:0] mask_ff;
  reg [31:0] pend_ff;
  wire [NUM_CMP-1:0] cmp_evt = cirq_s & ~cirq_d_ff;
  wire [NUM_WIN-1:0] win_evt = win_s & ~win_d_ff;
  wire [31:0] set_vec = irq_pack(cmp_evt, sut_done, win_evt);
  wire [31:0] valid = `CIRQ_IRQ_VALID;

  reg [31:0] nxt_mask;
  reg [31:0] nxt_pend;
  always @* begin
    nxt_mask = mask_ff;
    if (wr_mset) begin
      nxt_mask = nxt_mask | (wdata_i & valid);
    end
    if (wr_mclr) begin
      nxt_mask = nxt_mask & ~wdata_i;
    end
    nxt_pend = pend_ff;
    if (wr_pclr) begin
      nxt_pend = nxt_pend & ~wdata_i;
    end
    // A new event in the clearing cycle survives
    nxt_pend = (nxt_pend | set_vec) & valid;
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      mask_ff <= `CIRQ_RST_ZERO;
      pend_ff <= `CIRQ_RST_ZERO;
      cirq_d_ff <= {NUM_CMP{1'b0}};
      win_d_ff <= {NUM_WIN{1'b0}};
      en_d_ff <= {NUM_CMP{1'b0}};
    end else begin
      mask_ff <= nxt_mask;
      pend_ff <= nxt_pend;
      cirq_d_ff <= cirq_s;
      win_d_ff <= win_s;
      en_d_ff <= en_s;
    end
  end

  // Combinational from flags, so a clear drops the request with the flag
  assign irq_o = |(pend_ff & mask_ff);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [31:0] cap_val = {12'h000, WIN_PRESENT, 8'h00, CMP_PRESENT};
  wire [31:0] rev_val = {12'h000, REV_VARIANT, 4'h0, REV_NUMBER};

  reg [31:0] rdata_ff;
  reg [31:0] nxt_rdata;
  always @* begin
    nxt_rdata = `CIRQ_RST_ZERO;
    if (rd_i) begin
      case (addr_i)
        `CIRQ_CTRL_OFS: nxt_rdata = ctrl_ff;
        `CIRQ_MASK_OFS: nxt_rdata = mask_ff;
        `CIRQ_PEND_OFS: nxt_rdata = pend_ff;
        `CIRQ_OVR_OFS: nxt_rdata = {24'h00_0000, ovr_ff};
        `CIRQ_CAP_OFS: nxt_rdata = cap_val;
        `CIRQ_REV_OFS: nxt_rdata = rev_val;
        `CIRQ_SUT_OFS: nxt_rdata = {22'h00_0000, sut_ff};
        default: nxt_rdata = `CIRQ_RST_ZERO;
      endcase
    end
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_ff <= `CIRQ_RST_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;

endmodule

/* File: dv/cirq_props.sv */
`timescale 1ns/10ps
module cirq_props #(
  parameter NUM_CMP = 8
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire [NUM_CMP-1:0] cmp_out_o,
  input wire irq_o
);
  // ----------------------------------------
  // Shadow of mask and override state
  // ----------------------------------------
  reg [31:0] mask_ff;
  reg [8:0] ovr_ff;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      mask_ff <= 32'h0000_0000;
      ovr_ff <= 9'h000;
    end else if (wr_i) begin
      case (addr_i)
        8'h10: mask_ff <= mask_ff | (wdata_i & 32'h0f00_ffff);
        8'h14: mask_ff <= mask_ff & ~wdata_i;
        8'h00: ovr_ff[8] <= wdata_i[7];
        8'h24: ovr_ff[7:0] <= wdata_i[7:0];
        default: ;
      endcase
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("rdata not zero");
  chk_cap_read: assert property (rd_i && addr_i == 8'h30 |=> rdata_o == 32'h000f_00ff)
    else $error("capability wrong");
  chk_rev_read: assert property (rd_i && addr_i == 8'h34 |=> rdata_o == 32'h0000_0001)
    else $error("revision wrong");
  chk_mask_read: assert property (rd_i && addr_i == 8'h18 |=> rdata_o == mask_ff)
    else $error("mask wrong");
  chk_irq_needs_mask: assert property (irq_o |-> mask_ff != 32'h0000_0000)
    else $error("irq without mask");
  chk_irq_matches: assert property (rd_i && addr_i == 8'h1c |=> (|(rdata_o & mask_ff)) == $past(irq_o))
    else $error("irq disagrees");
  chk_ovr_out: assert property (ovr_ff[8] |-> cmp_out_o == ovr_ff[7:0])
    else $error("override not applied");
  chk_ovr_read: assert property (rd_i && addr_i == 8'h24 |=> rdata_o == {24'h00_0000, ovr_ff[7:0]})
    else $error("override readback wrong");
  cover property (irq_o);
  cover property (ovr_ff[8]);
  cover property (rd_i && addr_i == 8'h1c);
endmodule
bind cirq_regs cirq_props #(.NUM_CMP(NUM_CMP)) i_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .cmp_out_o(cmp_out_o), .irq_o(irq_o));

/* File: dv/tb.sv */
`timescale 1ns/10ps
module tb;
  reg ref_clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [7:0] addr_i = 8'h00;
  reg [31:0] wdata_i = 32'h0000_0000;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg [7:0] cmp_n = 8'h00;
  reg [7:0] cmp_irq = 8'h00;
  reg [3:0] win_irq = 4'h0;
  reg [7:0] cmp_en = 8'h00;
  wire [31:0] rdata_o;
  wire [7:0] cmp_out_o;
  wire [7:0] cmp_ready_o;
  wire irq_o;
  integer n_errors = 0;
  integer checks = 0;
  integer cycles = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  cirq_regs i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .comparator_n_i(cmp_n),
    .comparator_irq_i(cmp_irq), .window_pair_irq_i(win_irq), .cmp_enable_i(cmp_en),
    .cmp_out_o(cmp_out_o), .cmp_ready_o(cmp_ready_o), .irq_o(irq_o));
  // ----------------------------------------
  // Bus tasks and checking
  // ----------------------------------------
  task chk(input [31:0] seen, input [31:0] want);
    begin
      checks = checks + 1;
      if (seen !== want) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
      #1;
    end
  endtask
  task rd(input [7:0] a, input [31:0] want);
    begin
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, want);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Sized for the short test list; a hang ends the run here
  always @(posedge ref_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(8'h18, 32'h0000_0000);
    rd(8'h1c, 32'h0000_0000);
    rd(8'h24, 32'h0000_0000);
    rd(8'h30, 32'h000f_00ff);
    wr(8'h34, 32'hffff_ffff);
    rd(8'h34, 32'h0000_0001);
    rd(8'h3c, 32'h0000_0000);
    $display("test reset values done");
    wr(8'h10, 32'hffff_ffff);
    rd(8'h18, 32'h0f00_ffff);
    wr(8'h14, 32'h0100_0005);
    rd(8'h18, 32'h0e00_fffa);
    wr(8'h18, 32'h0000_0000);
    rd(8'h18, 32'h0e00_fffa);
    wr(8'h14, 32'hffff_ffff);
    rd(8'h18, 32'h0000_0000);
    $display("test mask done");
    wr(8'h38, 32'h0000_0003);
    @(posedge ref_clk_i);
    cmp_irq <= 8'h04;
    win_irq <= 4'h2;
    cmp_en <= 8'h01;
    repeat (20) @(posedge ref_clk_i);
    rd(8'h1c, 32'h0200_0012);
    chk({24'h00_0000, cmp_ready_o}, 32'h0000_0001);
    chk({31'h0, irq_o}, 32'h0000_0000);
    wr(8'h10, 32'h0000_0010);
    chk({31'h0, irq_o}, 32'h0000_0001);
    wr(8'h20, 32'h0000_0000);
    rd(8'h1c, 32'h0200_0012);
    chk({31'h0, irq_o}, 32'h0000_0001);
    wr(8'h1c, 32'hffff_ffff);
    rd(8'h1c, 32'h0200_0012);
    wr(8'h20, 32'h0000_0010);
    chk({31'h0, irq_o}, 32'h0000_0000);
    rd(8'h1c, 32'h0200_0002);
    wr(8'h10, 32'h0f00_ffff);
    chk({31'h0, irq_o}, 32'h0000_0001);
    wr(8'h20, 32'hffff_ffff);
    chk({31'h0, irq_o}, 32'h0000_0000);
    rd(8'h1c, 32'h0000_0000);
    $display("test pending done");
    @(posedge ref_clk_i);
    cmp_n <= 8'h3c;
    wr(8'h24, 32'h0000_00a5);
    wr(8'h00, 32'h0000_0080);
    chk({24'h00_0000, cmp_out_o}, 32'h0000_00a5);
    wr(8'h00, 32'h0000_0000);
    repeat (6) @(posedge ref_clk_i);
    chk({24'h00_0000, cmp_out_o}, 32'h0000_003c);
    rd(8'h24, 32'h0000_00a5);
    $display("test override done");
    report_and_stop;
  end
endmodule
